/* inc/tas_pkg.sv */
// Purpose: constants for the trace authentication status register block
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes:   offsets are word aligned

package tas_pkg;

    localparam int          WB_AW          = 8;
    localparam logic [7:0]  AUTH_OFS       = 8'hB8;
    localparam logic [7:0]  CFG_OFS        = 8'h00;
    localparam logic [7:0]  SYNC_OFS       = 8'h04;

    // field positions in the status word
    localparam int          SECURE_NONINVASIVE_STATE_LSB       = 6;
    localparam int          SID_LSB        = 4;
    localparam int          NONSECURE_NONINVASIVE_STATE_LSB      = 2;
    localparam int          NONSECURE_INVASIVE_STATE_LSB       = 0;

    // field codes
    localparam logic [1:0]  LVL_ABSENT     = 2'h0;
    localparam logic [1:0]  LVL_DISABLED   = 2'h2;
    localparam logic [1:0]  LVL_ENABLED    = 2'h3;
    localparam logic [1:0]  INV_NONE       = 2'h0;

    // profile select codes in the configuration register
    localparam logic [2:0]  PROF_OLD_SEC   = 3'h0;
    localparam logic [2:0]  PROF_OLD_NOSEC = 3'h1;
    localparam logic [2:0]  PROF_NEW_HEL   = 3'h2;
    localparam logic [2:0]  PROF_NEW_NOHEL = 3'h3;
    localparam logic [2:0]  PROF_RT32      = 3'h4;
    localparam logic [2:0]  PROF_RT64      = 3'h5;
    localparam logic [2:0]  PROF_MCU       = 3'h6;

    // configuration register layout
    localparam int          CFG_PROF_LSB   = 0;
    localparam int          CFG_TRF_BIT    = 4;
    localparam int          CFG_NONSECURE_NONINVASIVE_STATE_BIT  = 5;
    localparam logic [5:0]  CFG_RESET      = 6'h20;

    localparam logic [31:0] AUTH_RESET     = 32'h0000_0000;

endpackage

/* rtl/tas_auth_status.sv */
// Purpose: authentication status fields of a trace unit, read over Wishbone
// Assumes: enable inputs come from pins; security state from the processor
// Notes:   writes to the status word are ignored; config register chooses profile
//
// The implementer's own choices: the register addresses and the Wishbone register port.

`timescale 1ns/10ps

module tas_auth_status
(
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic [tas_pkg::WB_AW-1:0]  wb_adr_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    input  wire logic                       wb_we_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    output logic                            wb_ack_o,
    input  wire logic                       secure_invasive_enable_input,
    input  wire logic                       secure_noninvasive_enable_input,
    input  wire logic                       nonsecure_invasive_enable_input,
    input  wire logic                       nonsecure_noninvasive_enable_input,
    input  wire logic                       processor_secure_state,
    input  wire logic [1:0]                 proc_auth_secure_noninvasive,
    input  wire logic [1:0]                 proc_auth_nonsecure_noninvasive,
    input  wire logic                       debug_auth_override_control,
    input  wire logic                       override_secure_noninvasive,
    input  wire logic                       context_sync_event,
    output logic                            trace_prohibited
);
    import tas_pkg::*;

    // three-stage synchronisers for pin inputs
    logic [2:0] s_ni_q;
    logic [2:0] s_i_q;
    logic [2:0] ns_ni_q;
    logic [2:0] ns_i_q;
    logic [2:0] sec_q;
    logic       s_ni_st_q;
    logic       s_i_st_q;
    logic       ns_ni_st_q;
    logic       ns_i_st_q;
    logic       sec_st_q;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            s_ni_q <= 3'h0;
        else
            s_ni_q <= {s_ni_q[1:0], secure_noninvasive_enable_input};
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            s_i_q <= 3'h0;
        else
            s_i_q <= {s_i_q[1:0], secure_invasive_enable_input};
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            ns_ni_q <= 3'h0;
        else
            ns_ni_q <= {ns_ni_q[1:0], nonsecure_noninvasive_enable_input};
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            ns_i_q <= 3'h0;
        else
            ns_i_q <= {ns_i_q[1:0], nonsecure_invasive_enable_input};
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            sec_q <= 3'h0;
        else
            sec_q <= {sec_q[1:0], processor_secure_state};
    end

    // a change counts once stages two and three agree, so a glitch never lands
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            s_ni_st_q <= 1'b0;
        else if (s_ni_q[1] == s_ni_q[2])
            s_ni_st_q <= s_ni_q[2];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            s_i_st_q <= 1'b0;
        else if (s_i_q[1] == s_i_q[2])
            s_i_st_q <= s_i_q[2];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            ns_ni_st_q <= 1'b0;
        else if (ns_ni_q[1] == ns_ni_q[2])
            ns_ni_st_q <= ns_ni_q[2];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            ns_i_st_q <= 1'b0;
        else if (ns_i_q[1] == ns_i_q[2])
            ns_i_st_q <= ns_i_q[2];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            sec_st_q <= 1'b0;
        else if (sec_q[1] == sec_q[2])
            sec_st_q <= sec_q[2];
    end

    function automatic logic [1:0] lvl_code(input logic en);
        lvl_code = en ? LVL_ENABLED : LVL_DISABLED;
    endfunction

    logic [5:0]  cfg_q;
    logic        sync_pend_q;
    logic [31:0] auth_q;
    logic [1:0]  secure_noninvasive_state_d;
    logic [1:0]  nonsecure_noninvasive_state_d;
    logic        s_perm;
    logic        ns_perm;
    logic [2:0]  prof;
    logic        trf;

    assign prof = cfg_q[CFG_PROF_LSB +: 3];
    assign trf  = cfg_q[CFG_TRF_BIT];

    // nonsecure permitted if either enable given; trace filtering always permits it
    always_comb
    begin
        ns_perm = ns_i_st_q | ns_ni_st_q | trf;
    end

    // outside the MCU override, secure also needs the nonsecure level, so filtering feeds through here too
    always_comb
    begin
        s_perm = (s_i_st_q | s_ni_st_q) & ns_perm;
        if (prof == PROF_MCU && debug_auth_override_control)
            s_perm = override_secure_noninvasive;
    end

    always_comb
    begin
        secure_noninvasive_state_d = LVL_ABSENT;
        case (prof)
            PROF_OLD_SEC, PROF_NEW_HEL, PROF_MCU:
                secure_noninvasive_state_d = lvl_code(s_perm);
            PROF_OLD_NOSEC:
                secure_noninvasive_state_d = lvl_code(ns_perm);
            PROF_NEW_NOHEL, PROF_RT64:
            begin
                if (sec_st_q)
                    secure_noninvasive_state_d = lvl_code(s_perm);
            end
            PROF_RT32:
                secure_noninvasive_state_d = LVL_ABSENT;
            default:
                secure_noninvasive_state_d = LVL_ABSENT;
        endcase
        if (trf)
            secure_noninvasive_state_d = proc_auth_secure_noninvasive;
    end

    // field may be left unimplemented by the config bit, whatever the profile
    always_comb
    begin
        nonsecure_noninvasive_state_d = LVL_ABSENT;
        case (prof)
            PROF_OLD_SEC, PROF_NEW_HEL, PROF_MCU:
                nonsecure_noninvasive_state_d = lvl_code(ns_perm);
            PROF_OLD_NOSEC:
                nonsecure_noninvasive_state_d = LVL_ABSENT;
            PROF_NEW_NOHEL, PROF_RT64:
            begin
                if (!sec_st_q)
                    nonsecure_noninvasive_state_d = lvl_code(ns_perm);
            end
            PROF_RT32:
            begin
                if (!sec_st_q)
                    nonsecure_noninvasive_state_d = lvl_code(ns_perm);
            end
            default:
                nonsecure_noninvasive_state_d = LVL_ABSENT;
        endcase
        if (trf)
            nonsecure_noninvasive_state_d = proc_auth_nonsecure_noninvasive;
        if (!cfg_q[CFG_NONSECURE_NONINVASIVE_STATE_BIT])
            nonsecure_noninvasive_state_d = LVL_ABSENT;
    end

    // constants the logic cannot serve are refused at elaboration
    if (WB_AW < 8)
    begin : g_chk_aw
        $error("address bus too narrow for the register offsets");
    end

    if (SECURE_NONINVASIVE_STATE_LSB != SID_LSB + 2 || SID_LSB != NONSECURE_NONINVASIVE_STATE_LSB + 2 || NONSECURE_NONINVASIVE_STATE_LSB != NONSECURE_INVASIVE_STATE_LSB + 2)
    begin : g_chk_fields
        $error("status fields overlap or leave gaps");
    end

    if (SECURE_NONINVASIVE_STATE_LSB + 2 > 32)
    begin : g_chk_word
        $error("status fields outside the 32-bit word");
    end

    if (CFG_TRF_BIT >= 6 || CFG_NONSECURE_NONINVASIVE_STATE_BIT >= 6 || CFG_PROF_LSB + 3 > 6)
    begin : g_chk_cfg
        $error("config fields outside the config register");
    end

    if (AUTH_OFS == CFG_OFS || AUTH_OFS == SYNC_OFS || CFG_OFS == SYNC_OFS)
    begin : g_chk_ofs
        $error("register offsets alias");
    end

    // bus view only follows inputs after reset or a sync event, as a separate access path may lag
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            sync_pend_q <= 1'b1;
        else
            sync_pend_q <= context_sync_event;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            auth_q <= AUTH_RESET;
        else if (sync_pend_q)
        begin
            auth_q                         <= 32'h0000_0000;
            auth_q[SECURE_NONINVASIVE_STATE_LSB +: 2]          <= secure_noninvasive_state_d;
            auth_q[SID_LSB +: 2]           <= INV_NONE;
            auth_q[NONSECURE_NONINVASIVE_STATE_LSB +: 2]         <= nonsecure_noninvasive_state_d;
            auth_q[NONSECURE_INVASIVE_STATE_LSB +: 2]          <= INV_NONE;
        end
    end

    // in the MCU profile only, secure disabled blocks trace while in secure state
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            trace_prohibited <= 1'b0;
        else
            trace_prohibited <= (prof == PROF_MCU) && sec_st_q && !s_perm;
    end

    // wishbone slave, one wait state then ack
    logic req;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= req;
    end

    // only the low byte lane carries config bits; other offsets ignore writes
    logic        cfg_wr;
    logic [31:0] rd_word;

    assign cfg_wr = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == CFG_OFS);

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            cfg_q <= CFG_RESET;
        else if (cfg_wr)
            cfg_q <= wb_dat_i[5:0];
    end

    // unmapped offsets read as zero and are still acked
    always_comb
    begin
        case (wb_adr_i)
            AUTH_OFS:
                rd_word = auth_q;
            CFG_OFS:
                rd_word = {26'h0, cfg_q};
            SYNC_OFS:
                rd_word = {27'h0, sec_st_q, s_ni_st_q, s_i_st_q, ns_ni_st_q, ns_i_st_q};
            default:
                rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            wb_dat_o <= 32'h0000_0000;
        else if (req && !wb_we_i)
            wb_dat_o <= rd_word;
    end

endmodule

/* verification/tas_auth_status_checker.sv */
// Purpose: bus and field checks on the status block ports
// Assumes: classic single-cycle master
// Notes:   field codes checked only on status reads
`timescale 1ns/10ps
module tas_auth_status_checker
(
    input wire logic                      clk_sys,
    input wire logic                      rst_n,
    input wire logic [tas_pkg::WB_AW-1:0] wb_adr_i,
    input wire logic                      wb_we_i,
    input wire logic                      wb_cyc_i,
    input wire logic                      wb_stb_i,
    input wire logic                      wb_ack_o,
    input wire logic [31:0]               wb_dat_o
);
    import tas_pkg::*;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    wire rd_st = wb_ack_o && !wb_we_i && wb_adr_i == AUTH_OFS;
    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_secure_noninvasive_state_code: assert property (rd_st |-> wb_dat_o[7:6] != 2'h1) else $error("bad code 7:6");
    a_sid_zero: assert property (rd_st |-> wb_dat_o[5:4] == INV_NONE) else $error("bits 5:4 set");
    a_nonsecure_noninvasive_state_code: assert property (rd_st |-> wb_dat_o[3:2] != 2'h1) else $error("bad code 3:2");
    a_nonsecure_invasive_state_zero: assert property (rd_st |-> wb_dat_o[1:0] == INV_NONE) else $error("bits 1:0 set");
    a_write_keeps: assert property (wb_cyc_i && wb_stb_i && wb_we_i |=> $stable(wb_dat_o))
        else $error("write moved read data");
endmodule

bind tas_auth_status tas_auth_status_checker chk_u (.*);

/* verification/tas_proc_model.sv */
// Purpose: processor side: pins, security state, status fields
// Assumes: bit order {si,sni,nsi,nsni,sec,ps[1:0],pns[1:0],ovc,ov}
// Notes:   waits for the pin synchronisers before the sync pulse
`timescale 1ns/10ps
module tas_proc_model
(
    input  wire logic        clk_sys,
    output logic      [10:0] proc_q,
    output logic             sync_q
);
    initial
    begin
        proc_q = 11'h000;
        sync_q = 1'b0;
    end
    task automatic set(input logic [10:0] v, input logic sy);
        @(posedge clk_sys);
        proc_q <= v;
        repeat (6) @(posedge clk_sys);
        sync_q <= sy;
        @(posedge clk_sys);
        sync_q <= 1'b0;
        @(posedge clk_sys);
    endtask
endmodule

/* verification/tas_auth_status_tb.sv */
// Purpose: register level test of the status block
// Assumes: one Wishbone master task
// Notes:   32-bit real-time secure state left out, undefined
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value at %0t: %h not %h", $time, a, b); end end
module tas_auth_status_tb;
    import tas_pkg::*;
    logic        clk_sys, rst_n, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, trace_prohibited, sync_q;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, d;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [10:0] pq;
    logic [8:0]  e;
    int          n_fail, samples_checked;
    localparam logic [10:0] PAT [5] = '{11'h000, 11'h0B8, 11'h46C, 11'h043, 11'h300};
    tas_proc_model pm_u (.clk_sys(clk_sys), .proc_q(pq), .sync_q(sync_q));
    tas_auth_status dut_u (.*, .secure_invasive_enable_input(pq[10]),
        .secure_noninvasive_enable_input(pq[9]), .nonsecure_invasive_enable_input(pq[8]),
        .nonsecure_noninvasive_enable_input(pq[7]), .processor_secure_state(pq[6]),
        .proc_auth_secure_noninvasive(pq[5:4]), .proc_auth_nonsecure_noninvasive(pq[3:2]),
        .debug_auth_override_control(pq[1]), .override_secure_noninvasive(pq[0]),
        .context_sync_event(sync_q));
    function automatic logic [8:0] ex(logic [2:0] p, logic t, logic [10:0] v);
        logic       n, s, sp;
        logic [1:0] a, b;
        n = v[8] | v[7] | t;
        s = (p == PROF_MCU && v[1]) ? v[0] : (v[10] | v[9]) & n;
        sp = p inside {PROF_NEW_NOHEL, PROF_RT64};
        a = {1'b1, (p == PROF_OLD_NOSEC) ? n : s};
        b = {1'b1, n};
        if (p == PROF_OLD_NOSEC || (sp && v[6])) b = 2'h0;
        if (p == PROF_RT32 || (sp && !v[6])) a = 2'h0;
        if (t) {a, b} = {v[5:4], v[3:2]};
        return {p == PROF_MCU && v[6] && !s, a, 2'h0, b, 2'h0};
    endfunction
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, wd};
        do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    task automatic conclude;
        $display("checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        conclude();
    end
    initial
    begin
        {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        wb(0, CFG_OFS, 0, d); `CHK(d, {26'h0, CFG_RESET})
        wb(0, 8'h40, 0, d); `CHK(d, 32'h0)
        $display("test reset done");
        for (int p = 0; p < 7; p++)
            for (int t = 0; t < 2; t++)
                for (int i = 0; i < 5; i++)
                begin
                    if (p == PROF_RT32 && PAT[i][6]) continue;
                    wb(1, CFG_OFS, {26'h0, 1'b1, t[0], 1'b0, p[2:0]}, d);
                    pm_u.set(PAT[i], 1'b1);
                    wb(0, AUTH_OFS, 0, d);
                    e = ex(p[2:0], t[0], PAT[i]);
                    `CHK(d, {24'h0, e[7:0]})
                    `CHK(trace_prohibited, e[8])
                end
        $display("test profiles done");
        wb(1, CFG_OFS, 32'h20, d);
        pm_u.set(11'h300, 1'b1);
        pm_u.set(11'h000, 1'b0);
        wb(0, AUTH_OFS, 0, d); `CHK(d, 32'hCC)
        pm_u.set(11'h000, 1'b1);
        wb(1, AUTH_OFS, 32'hFFFF_FFFF, d);
        wb(0, AUTH_OFS, 0, d); `CHK(d, 32'h88)
        wb(1, CFG_OFS, 32'h00, d);
        pm_u.set(11'h300, 1'b1);
        wb(0, AUTH_OFS, 0, d); `CHK(d, 32'hC0)
        $display("test sync and write done");
        conclude();
    end
endmodule
